// file: shared/wtu_cnt_if.sv
/*
 * Carrier between the watchdog control logic and its down-counter.
 * Assumes both ends share one clock and reset.
 */
`timescale 1ns/100ps
`default_nettype none

interface wtu_cnt_if;
    logic load;
    logic [wtu_pkg::CNT_W-1:0] load_val;
    logic dec;
    logic [wtu_pkg::CNT_W-1:0] count;
    logic is_zero;

    modport ctl (output load, output load_val, output dec, input count, input is_zero);
    modport cnt (input load, input load_val, input dec, output count, output is_zero);
endinterface : wtu_cnt_if

`default_nettype wire

// file: shared/wtu_pkg.sv
/*
 * Constants for the watchdog time-out unit: register offsets, field positions,
 * reset values and counter limits.
 * Assumes a 32-bit APB register port and a 24-bit watchdog down-counter.
 */
// What this block does
// - On first enable, load the counter from the reload register before counting.
// - Count down toward zero unless the core issues a refresh.
// - A refresh reloads the counter from the reload register; counting then resumes.
// - Reaching zero is a time-out event.
// - A time-out gives an interrupt or a system reset, chosen by an option bit.
// - Option bit 1 (unprogrammed) requests reset, in normal or stop; 0 requests interrupt.
// - A time-out reset sets the watchdog cause bit in the reset-cause register.
// - Interrupt mode: time-out requests an interrupt and sets the watchdog status flag.
// - After an interrupt-mode time-out the counter restarts from its maximum value.
// - Reading the reset-cause register clears the flag; until then a repeat time-out outside stop requests no interrupt.
// - Interrupt mode in stop: time-out requests stop recovery and the interrupt.
// - An interrupt-mode time-out in stop sets the status flag and the stop-recovery flag.
// - In debug mode the watchdog is refreshed continuously, so no time-out occurs.

package wtu_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 24;
    localparam int INT_W = 2;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RELOAD = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_CAUSE = 8'h0C;
    localparam logic [7:0] OFS_INT_STAT = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_STOP_BIT = 8;
    localparam int CAUSE_TMO_BIT = 0;
    localparam int CAUSE_RST_BIT = 1;
    localparam int INT_TMO_BIT = 0;
    localparam int INT_STOP_BIT = 1;

    // counter limits and reset values
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_MAX = 24'h0FFFFF;
    localparam logic [CNT_W-1:0] RELOAD_RST = 24'h00FFFF;
    localparam logic OPT_RST = 1'b1;
    localparam logic [INT_W-1:0] INT_MASK_RST = 2'h0;

endpackage : wtu_pkg

// file: verif/tb_top.sv
/* Self-checking bench for the watchdog time-out unit over APB.
   Assumes the partner model answers reset and interrupt requests. */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic clock = 1'b0;
    logic tb_rst = 1'b1;
    logic por_rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic refresh_req = 1'b0;
    logic stop_mode = 1'b0;
    logic debug_mode = 1'b0;
    logic timeout_response_select = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, wdt_intr_req, stop_recovery_req, system_reset_req, irq, rst_out, sys_rst;
    logic [7:0] n_rst, n_intr, n_wake;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    assign sys_rst = tb_rst | rst_out;
    always #12.5 clock = ~clock;

    wtu_top wtu_top_inst (.clock, .sys_rst, .por_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .refresh_req, .stop_mode, .debug_mode, .timeout_response_select, .wdt_intr_req,
        .stop_recovery_req, .system_reset_req, .irq);
    wtu_partner wtu_partner_inst (.clock, .system_reset_req, .wdt_intr_req, .stop_recovery_req, .rst_out,
        .n_rst, .n_intr, .n_wake);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    // whole apb transfer; the answer time is not assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
    endtask : rdc

    // cycles until the partner sees a reset or interrupt request
    task automatic wait_evt(output int n);
        logic [7:0] r0;
        logic [7:0] i0;
        r0 = n_rst;
        i0 = n_intr;
        n = 0;
        while (n_rst === r0 && n_intr === i0 && n < 300) begin
            @(posedge clock);
            n++;
        end
    endtask : wait_evt

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // hang guard, far above the few hundred cycles needed
    always @(posedge clock) begin
        cycles++;
        if (cycles > 3000) begin
            n_fail++;
            $display("Error at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    initial begin
        int n;
        logic [31:0] v;
        logic e;
        repeat (2) @(posedge clock);
        tb_rst <= 1'b0;
        por_rst <= 1'b0;
        @(posedge clock);
        rdc(wtu_pkg::OFS_RELOAD, {8'h00, wtu_pkg::RELOAD_RST});
        rdc(wtu_pkg::OFS_CTRL, 32'h0);
        apb(1'b0, 8'h18, 32'h0, v, e);
        chk({31'h0, e}, 32'h1);
        // reset response, cause bit kept over the system reset
        wr(wtu_pkg::OFS_RELOAD, 32'h10);
        wr(wtu_pkg::OFS_CTRL, 32'h1);
        wait_evt(n);
        chk(32'(n >= 14 && n <= 21), 32'h1);
        chk({16'h0, n_rst, n_intr}, 32'h0100);
        repeat (4) @(posedge clock);
        rdc(wtu_pkg::OFS_CAUSE, 32'h2);
        rdc(wtu_pkg::OFS_CAUSE, 32'h0);
        // refresh pulses, then debug, keep it from timing out
        wr(wtu_pkg::OFS_RELOAD, 32'h10);
        wr(wtu_pkg::OFS_CTRL, 32'h1);
        repeat (8) begin
            repeat (6) @(posedge clock);
            refresh_req <= 1'b1;
            @(posedge clock);
            refresh_req <= 1'b0;
        end
        debug_mode <= 1'b1;
        repeat (60) @(posedge clock);
        debug_mode <= 1'b0;
        chk({24'h0, n_rst}, 32'h1);
        wait_evt(n);
        chk(32'(n >= 14 && n <= 21), 32'h1);
        // interrupt response after a reset with the option at 0
        timeout_response_select <= 1'b0;
        tb_rst <= 1'b1;
        repeat (4) @(posedge clock);
        tb_rst <= 1'b0;
        @(posedge clock);
        rdc(wtu_pkg::OFS_CAUSE, 32'h2);
        wr(wtu_pkg::OFS_INT_MASK, 32'h3);
        wr(wtu_pkg::OFS_RELOAD, 32'h10);
        wr(wtu_pkg::OFS_CTRL, 32'h1);
        wait_evt(n);
        chk({16'h0, n_rst, n_intr}, 32'h0201);
        apb(1'b0, wtu_pkg::OFS_COUNT, 32'h0, v, e);
        chk(32'(v <= wtu_pkg::CNT_MAX && v > wtu_pkg::CNT_MAX - 24'h40), 32'h1);
        chk({31'h0, irq}, 32'h1);
        // second time-out with the flag still set: no new request
        refresh_req <= 1'b1;
        @(posedge clock);
        refresh_req <= 1'b0;
        repeat (24) @(posedge clock);
        chk({24'h0, n_intr}, 32'h1);
        apb(1'b0, wtu_pkg::OFS_COUNT, 32'h0, v, e);
        chk(32'(v > wtu_pkg::CNT_MAX - 24'h40), 32'h1);
        rdc(wtu_pkg::OFS_CAUSE, 32'h1);
        rdc(wtu_pkg::OFS_CAUSE, 32'h0);
        wr(wtu_pkg::OFS_INT_STAT, 32'h1);
        rdc(wtu_pkg::OFS_INT_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // time-out while stopped wakes the device
        stop_mode <= 1'b1;
        refresh_req <= 1'b1;
        @(posedge clock);
        refresh_req <= 1'b0;
        wait_evt(n);
        chk(32'(n >= 14 && n <= 21), 32'h1);
        chk({24'h0, n_wake}, 32'h1);
        rdc(wtu_pkg::OFS_CTRL, 32'h101);
        rdc(wtu_pkg::OFS_INT_STAT, 32'h3);
        rdc(wtu_pkg::OFS_CAUSE, 32'h1);
        rdc(wtu_pkg::OFS_CTRL, 32'h1);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire

// file: verif/wtu_checker.sv
/* Port checker for the watchdog time-out unit.
   Assumes binding to wtu_top; one clock, synchronous active-high resets. */
`timescale 1ns/100ps
`default_nettype none

module wtu_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stop_mode,
    input wire logic debug_mode,
    input wire logic wdt_intr_req,
    input wire logic stop_recovery_req,
    input wire logic system_reset_req
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst || por_rst);

    // first access edge of a transfer
    sequence s_access;
        psel && $rose(penable);
    endsequence

    // debug held for two edges, so any time-out decision was a reload
    sequence s_debug_held;
        debug_mode && $past(debug_mode);
    endsequence

    AST_PREADY_WAIT: // one wait state, then ready
        assert property (s_access |-> !pready ##1 pready) else $error("ready not after one wait state");
    AST_PREADY_PULSE: // ready lasts one cycle
        assert property (pready |=> !pready) else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: // error only with ready
        assert property (pslverr |-> pready) else $error("error without ready");
    AST_RST_PULSE:
        assert property (system_reset_req |=> !system_reset_req) else $error("reset request not a pulse");
    AST_INTR_PULSE:
        assert property (wdt_intr_req |=> !wdt_intr_req) else $error("interrupt request not a pulse");
    AST_ONE_RESPONSE:
        assert property (!(system_reset_req && wdt_intr_req)) else $error("both time-out responses at once");
    AST_STOP_WITH_INTR:
        assert property (stop_recovery_req |-> wdt_intr_req && $past(stop_mode)) else $error("bad stop recovery");
    AST_DEBUG_QUIET:
        assert property (s_debug_held |-> !wdt_intr_req && !system_reset_req) else $error("time-out in debug");
endmodule : wtu_checker

bind wtu_top wtu_checker wtu_checker_inst (.clock, .sys_rst, .por_rst, .psel, .penable, .pready, .pslverr,
    .stop_mode, .debug_mode, .wdt_intr_req, .stop_recovery_req, .system_reset_req);

`default_nettype wire

// file: verif/wtu_partner.sv
/* Model of the reset controller and interrupt controller beside the watchdog.
   Assumes the request pulses are registered on the same clock. */
`timescale 1ns/100ps
`default_nettype none

module wtu_partner (
    input wire logic clock,
    input wire logic system_reset_req,
    input wire logic wdt_intr_req,
    input wire logic stop_recovery_req,
    output logic rst_out,
    output logic [7:0] n_rst,
    output logic [7:0] n_intr,
    output logic [7:0] n_wake
);
    logic [1:0] hold;

    initial begin
        hold = 2'h0;
        n_rst = 8'h00;
        n_intr = 8'h00;
        n_wake = 8'h00;
    end

    // two-cycle system reset per request; counters survive it on purpose
    always @(posedge clock) begin
        hold <= (system_reset_req === 1'b1) ? 2'h2 : (hold != 2'h0) ? hold - 2'h1 : 2'h0;
        n_rst <= n_rst + {7'h00, system_reset_req === 1'b1};
        n_intr <= n_intr + {7'h00, wdt_intr_req === 1'b1};
        n_wake <= n_wake + {7'h00, stop_recovery_req === 1'b1};
    end
    assign rst_out = (hold != 2'h0);
endmodule : wtu_partner

`default_nettype wire

// file: verilog/wtu_counter.sv
/*
 * 24-bit watchdog down-counter with load and decrement strobes.
 * Assumes load and dec come from logic on the same clock; load wins.
 */
`timescale 1ns/100ps
`default_nettype none

module wtu_counter (
    input wire logic clock,
    input wire logic sys_rst,
    wtu_cnt_if.cnt cnt
);

    typedef struct packed {
        logic [wtu_pkg::CNT_W-1:0] count;
    } wtu_cnt_state_s;

    wtu_cnt_state_s s;
    wtu_cnt_state_s next_s;

    // load takes priority over counting down
    always_comb begin
        next_s = s;
        if (cnt.load) begin
            next_s.count = cnt.load_val;
        end else if (cnt.dec && s.count != wtu_pkg::CNT_ZERO) begin
            next_s.count = s.count - 24'h000001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s <= '{count: wtu_pkg::CNT_MAX};
        end else begin
            s <= next_s;
        end
    end

    // zero flag straight off the count register
    assign cnt.count = s.count;
    assign cnt.is_zero = (s.count == wtu_pkg::CNT_ZERO);

endmodule : wtu_counter

`default_nettype wire

// file: verilog/wtu_top.sv
/*
 * Watchdog time-out unit: APB register slave, enable/refresh/time-out control,
 * reset-cause and stop-recovery flags, and a maskable level interrupt.
 * Assumes refresh, stop, debug and the option bit come from logic on the
 * same 40 MHz clock; por_rst clears what must survive a system reset.
 */
`timescale 1ns/100ps
`default_nettype none

module wtu_top (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic por_rst,
    input wire logic [wtu_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wtu_pkg::DATA_W-1:0] pwdata,
    output logic [wtu_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic refresh_req,
    input wire logic stop_mode,
    input wire logic debug_mode,
    input wire logic timeout_response_select,
    output logic wdt_intr_req,
    output logic stop_recovery_req,
    output logic system_reset_req,
    output logic irq
);

    typedef struct packed {
        logic opt_caught;
        logic opt_reset;
        logic enable;
        logic enable_q;
        logic [wtu_pkg::CNT_W-1:0] reload;
        logic tmo_flag;
        logic rst_cause;
        logic stop_flag;
        logic [wtu_pkg::INT_W-1:0] int_stat;
        logic [wtu_pkg::INT_W-1:0] int_mask;
        logic [wtu_pkg::DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic wdt_intr_req;
        logic stop_recovery_req;
        logic system_reset_req;
        logic irq;
    } wtu_state_s;

    localparam wtu_state_s RESET_S = '{
        opt_caught: 1'b0,
        opt_reset: wtu_pkg::OPT_RST,
        enable: 1'b0,
        enable_q: 1'b0,
        reload: wtu_pkg::RELOAD_RST,
        tmo_flag: 1'b0,
        rst_cause: 1'b0,
        stop_flag: 1'b0,
        int_stat: 2'h0,
        int_mask: wtu_pkg::INT_MASK_RST,
        prdata: 32'h00000000,
        pready: 1'b0,
        pslverr: 1'b0,
        wdt_intr_req: 1'b0,
        stop_recovery_req: 1'b0,
        system_reset_req: 1'b0,
        irq: 1'b0
    };

    wtu_state_s s;
    wtu_state_s next_s;

    wtu_cnt_if cnt_if ();

    wtu_counter u_counter (
        .clock(clock),
        .sys_rst(sys_rst || por_rst),
        .cnt(cnt_if.cnt)
    );

    // bus decode helpers
    logic addr_hit;
    logic [wtu_pkg::DATA_W-1:0] read_word;
    logic bus_done;
    logic bus_wr;
    logic bus_rd_cause;
    logic timeout;
    logic [wtu_pkg::INT_W-1:0] int_set;
    logic [wtu_pkg::INT_W-1:0] int_clr;

    // read mux, decoded during the first access cycle
    always_comb begin
        addr_hit = 1'b1;
        read_word = 32'h00000000;
        unique case (paddr)
            wtu_pkg::OFS_CTRL: begin
                read_word[wtu_pkg::CTRL_EN_BIT] = s.enable;
                read_word[wtu_pkg::CTRL_STOP_BIT] = s.stop_flag;
            end
            wtu_pkg::OFS_RELOAD: begin
                read_word[wtu_pkg::CNT_W-1:0] = s.reload;
            end
            wtu_pkg::OFS_COUNT: begin
                read_word[wtu_pkg::CNT_W-1:0] = cnt_if.count;
            end
            wtu_pkg::OFS_CAUSE: begin
                read_word[wtu_pkg::CAUSE_TMO_BIT] = s.tmo_flag;
                read_word[wtu_pkg::CAUSE_RST_BIT] = s.rst_cause;
            end
            wtu_pkg::OFS_INT_STAT: begin
                read_word[wtu_pkg::INT_W-1:0] = s.int_stat;
            end
            wtu_pkg::OFS_INT_MASK: begin
                read_word[wtu_pkg::INT_W-1:0] = s.int_mask;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // transfer completes on the edge where pready is seen high
    assign bus_done = psel && penable && s.pready;
    assign bus_wr = bus_done && pwrite && !s.pslverr;
    assign bus_rd_cause = bus_done && !pwrite && !s.pslverr && paddr == wtu_pkg::OFS_CAUSE;

    // control, counter steering and register updates
    always_comb begin
        next_s = s;
        timeout = 1'b0;
        int_set = 2'h0;
        int_clr = 2'h0;
        cnt_if.load = 1'b0;
        cnt_if.load_val = s.reload;
        cnt_if.dec = 1'b0;
        next_s.wdt_intr_req = 1'b0;
        next_s.stop_recovery_req = 1'b0;
        next_s.system_reset_req = 1'b0;

        // option bit caught once after reset release, then held
        if (!s.opt_caught) begin
            next_s.opt_caught = 1'b1;
            next_s.opt_reset = timeout_response_select;
        end

        // apb: one wait state, pready and data from flops
        next_s.pready = psel && penable && !s.pready;
        if (psel && penable && !s.pready) begin
            next_s.prdata = pwrite ? 32'h00000000 : read_word;
            next_s.pslverr = !addr_hit;
        end else begin
            next_s.pslverr = 1'b0;
        end

        // register writes
        if (bus_wr) begin
            unique case (paddr)
                wtu_pkg::OFS_CTRL: next_s.enable = pwdata[wtu_pkg::CTRL_EN_BIT];
                wtu_pkg::OFS_RELOAD: next_s.reload = pwdata[wtu_pkg::CNT_W-1:0];
                wtu_pkg::OFS_INT_STAT: int_clr = pwdata[wtu_pkg::INT_W-1:0];
                wtu_pkg::OFS_INT_MASK: next_s.int_mask = pwdata[wtu_pkg::INT_W-1:0];
                default: ;
            endcase
        end
        next_s.enable_q = s.enable;

        if (bus_rd_cause) begin
            next_s.tmo_flag = 1'b0;
            next_s.rst_cause = 1'b0;
            next_s.stop_flag = 1'b0;
        end

        if (s.enable && !s.enable_q) begin
            cnt_if.load = 1'b1;
        end else if (s.enable && debug_mode) begin
            cnt_if.load = 1'b1;
        end else if (s.enable && refresh_req) begin
            cnt_if.load = 1'b1;
        end else if (s.enable && cnt_if.is_zero) begin
            timeout = 1'b1;
        end else if (s.enable) begin
            cnt_if.dec = 1'b1;
        end

        if (timeout && s.opt_reset) begin
            next_s.system_reset_req = 1'b1;
            next_s.rst_cause = 1'b1;
            cnt_if.load = 1'b1;
        end else if (timeout) begin
            cnt_if.load = 1'b1;
            cnt_if.load_val = wtu_pkg::CNT_MAX;
            // interrupt and status flag; set wins over a read clear
            next_s.tmo_flag = 1'b1;
            // outside stop, no repeat while flag still set
            next_s.wdt_intr_req = !s.tmo_flag;
            int_set[wtu_pkg::INT_TMO_BIT] = 1'b1;
            if (stop_mode) begin
                next_s.stop_recovery_req = 1'b1;
                next_s.wdt_intr_req = 1'b1;
                next_s.stop_flag = 1'b1;
                int_set[wtu_pkg::INT_STOP_BIT] = 1'b1;
            end
        end

        // sticky until cleared; set wins over write-one-clear
        next_s.int_stat = (s.int_stat & ~int_clr) | int_set;
        next_s.irq = |(next_s.int_stat & next_s.int_mask);
    end

    // cause bit must outlive the system reset it triggers
    always_ff @(posedge clock) begin
        if (por_rst) begin
            s <= RESET_S;
        end else if (sys_rst) begin
            s <= RESET_S;
            s.rst_cause <= s.rst_cause;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign wdt_intr_req = s.wdt_intr_req;
    assign stop_recovery_req = s.stop_recovery_req;
    assign system_reset_req = s.system_reset_req;
    assign irq = s.irq;

endmodule : wtu_top

`default_nettype wire
